// >>> core/uhoc_pkg.sv
// package for the host operating-control register block
// assumes a single 32-bit word register reached over a simple slave port
package uhoc_pkg;

  // ************************************************
  // register map
  // ************************************************
  localparam logic [31:0] CTRL_ADDR = 32'hfff05004;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam int RATIO_LSB = 0;
  localparam int PERIODIC_BIT = 2;
  localparam int ISO_BIT = 3;
  localparam int CLE_BIT = 4;
  localparam int BULK_BIT = 5;
  localparam int FS_LSB = 6;
  localparam int ROUTE_BIT = 8;
  localparam int WAKE_PRESENT_BIT = 9;
  localparam int WAKE_CONNECT_BIT = 10;
  localparam logic [31:0] WR_MASK = 32'h000005ff;

  typedef enum logic [1:0] {
    FS_RESET = 2'h0,
    FS_RESUME = 2'h1,
    FS_OPER = 2'h2,
    FS_SUSPEND = 2'h3
  } uhoc_fs_t;

  typedef enum logic [1:0] {
    LS_IDLE,
    LS_CTRL,
    LS_BULK
  } uhoc_list_t;

  typedef struct packed {
    logic remote_wake_connect_permit;
    logic interrupt_routing_select;
    uhoc_fs_t functional_state;
    logic bulk_queue_permit;
    logic control_queue_permit;
    logic iso_service_permit;
    logic periodic_queue_permit;
    logic [1:0] control_bulk_ratio;
  } uhoc_ctrl_t;

endpackage

// >>> core/uhoc_ctrl.sv
// operating-control register and list-scheduling gates of a usb host
// assumes a simple synchronous slave port (sel, write, addr, wdata) on clk
module uhoc_ctrl #(
  parameter int CNT_W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_ready,
  input wire logic resume_detect,
  input wire logic hc_irq,
  input wire logic frame_start,
  input wire logic iso_ed_found,
  input wire logic nonperiodic_slot,
  output logic normal_interrupt,
  output logic system_management_interrupt,
  output logic [1:0] functional_state,
  output logic periodic_frame_go,
  output logic iso_go,
  output logic ctrl_go,
  output logic bulk_go
);

  // ************************************************
  // parameter checks
  // ************************************************
  // the control counter must reach ratio plus one, up to four
  if (CNT_W < 3) begin : g_bad_width
    $error("control counter width too small for ratio field");
  end

  // ************************************************
  // input synchronisers
  // ************************************************
  logic [1:0] resume_sync;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resume_sync <= 2'h0;
    end else begin
      resume_sync <= {resume_sync[0], resume_detect};
    end
  end
  wire resume_seen = resume_sync[1];

  // ************************************************
  // register and slave port
  // ************************************************
  uhoc_pkg::uhoc_ctrl_t ctrl;
  uhoc_pkg::uhoc_ctrl_t next_ctrl;
  wire hit = bus_sel && (bus_addr == uhoc_pkg::CTRL_ADDR);
  wire wr_hit = hit && bus_write;
  wire [31:0] wmask = bus_wdata & uhoc_pkg::WR_MASK;
  wire suspend_wake = resume_seen && (ctrl.functional_state == uhoc_pkg::FS_SUSPEND);
  // register image: bit 9 tied low, bits above ten zero
  wire [31:0] rd_image = {21'h0, ctrl.remote_wake_connect_permit, 1'b0,
    ctrl.interrupt_routing_select, ctrl.functional_state, ctrl.bulk_queue_permit,
    ctrl.control_queue_permit, ctrl.iso_service_permit, ctrl.periodic_queue_permit,
    ctrl.control_bulk_ratio};

  always_comb begin
    next_ctrl = ctrl;
    if (wr_hit) begin
      next_ctrl.remote_wake_connect_permit = wmask[uhoc_pkg::WAKE_CONNECT_BIT];
      next_ctrl.interrupt_routing_select = wmask[uhoc_pkg::ROUTE_BIT];
      next_ctrl.functional_state = uhoc_pkg::uhoc_fs_t'(wmask[uhoc_pkg::FS_LSB +: 2]);
      next_ctrl.bulk_queue_permit = wmask[uhoc_pkg::BULK_BIT];
      next_ctrl.control_queue_permit = wmask[uhoc_pkg::CLE_BIT];
      next_ctrl.iso_service_permit = wmask[uhoc_pkg::ISO_BIT];
      next_ctrl.periodic_queue_permit = wmask[uhoc_pkg::PERIODIC_BIT];
      next_ctrl.control_bulk_ratio = wmask[uhoc_pkg::RATIO_LSB +: 2];
    end else if (suspend_wake) begin
      // a software write in the same cycle takes priority
      next_ctrl.functional_state = uhoc_pkg::FS_RESUME;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= uhoc_pkg::uhoc_ctrl_t'({uhoc_pkg::CTRL_RESET[10], uhoc_pkg::CTRL_RESET[8:0]});
      bus_rdata <= 32'h0;
      bus_ready <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      bus_rdata <= (hit && !bus_write) ? rd_image : 32'h0;
      bus_ready <= bus_sel;
    end
  end

  // ************************************************
  // interrupt routing and list gating
  // ************************************************
  wire oper = (ctrl.functional_state == uhoc_pkg::FS_OPER);
  logic periodic_frame;
  logic [CNT_W-1:0] ctrl_cnt;
  uhoc_pkg::uhoc_list_t list_turn;
  // field holds count minus one, so bulk waits for ratio plus one controls
  wire [CNT_W-1:0] ratio_limit = CNT_W'(ctrl.control_bulk_ratio) + CNT_W'(1);
  wire ratio_done = (ctrl_cnt == ratio_limit);
  wire pick_ctrl = ctrl.control_queue_permit &&
    (!ctrl.bulk_queue_permit || !ratio_done);
  wire pick_bulk = ctrl.bulk_queue_permit && !pick_ctrl;
  wire next_periodic_frame = frame_start ? ctrl.periodic_queue_permit : periodic_frame;
  // with bulk off each control pick clears the count, so it restarts clean when bulk returns
  wire [CNT_W-1:0] next_ctrl_cnt = ctrl.bulk_queue_permit ? ctrl_cnt + CNT_W'(1) :
    {CNT_W{1'b0}};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      normal_interrupt <= 1'b0;
      system_management_interrupt <= 1'b0;
      functional_state <= 2'h0;
      periodic_frame <= 1'b0;
      periodic_frame_go <= 1'b0;
      iso_go <= 1'b0;
      ctrl_go <= 1'b0;
      bulk_go <= 1'b0;
      ctrl_cnt <= {CNT_W{1'b0}};
      list_turn <= uhoc_pkg::LS_IDLE;
    end else begin
      normal_interrupt <= hc_irq && !ctrl.interrupt_routing_select;
      system_management_interrupt <= hc_irq && ctrl.interrupt_routing_select;
      functional_state <= ctrl.functional_state;
      periodic_frame <= next_periodic_frame;
      periodic_frame_go <= oper && next_periodic_frame;
      iso_go <= oper && next_periodic_frame && iso_ed_found && ctrl.iso_service_permit;
      ctrl_go <= oper && nonperiodic_slot && pick_ctrl;
      bulk_go <= oper && nonperiodic_slot && pick_bulk;
      if (oper && nonperiodic_slot && pick_ctrl) begin
        ctrl_cnt <= next_ctrl_cnt;
        list_turn <= uhoc_pkg::LS_CTRL;
      end else if (oper && nonperiodic_slot && pick_bulk) begin
        ctrl_cnt <= {CNT_W{1'b0}};
        list_turn <= uhoc_pkg::LS_BULK;
      end
    end
  end

  // ************************************************
  // checks
  // ************************************************
  a_wake_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
    bus_ready && $past(hit && !bus_write) |-> bus_rdata[uhoc_pkg::WAKE_PRESENT_BIT] == 1'b0)
    else $error("wake present bit read as one");
  a_high_bits_zero: assert property (@(posedge clk) disable iff (!nrst)
    bus_rdata[31:11] == 21'h0)
    else $error("reserved bits read nonzero");
  a_route_smi: assert property (@(posedge clk) disable iff (!nrst)
    hc_irq && ctrl.interrupt_routing_select |=> system_management_interrupt && !normal_interrupt)
    else $error("interrupt not routed to management line");
  a_suspend_resume: assert property (@(posedge clk) disable iff (!nrst)
    suspend_wake && !wr_hit |=> ctrl.functional_state == uhoc_pkg::FS_RESUME)
    else $error("suspend did not move to resume");
  a_bulk_gate: assert property (@(posedge clk) disable iff (!nrst)
    bulk_go |-> $past(ctrl.bulk_queue_permit))
    else $error("bulk served while disabled");
  a_ctrl_gate: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_go |-> $past(ctrl.control_queue_permit))
    else $error("control served while disabled");
  a_iso_gate: assert property (@(posedge clk) disable iff (!nrst)
    iso_go |-> $past(ctrl.iso_service_permit) && periodic_frame_go)
    else $error("iso served while disabled");
  a_frame_sample: assert property (@(posedge clk) disable iff (!nrst)
    frame_start && oper && !ctrl.periodic_queue_permit |=> !periodic_frame_go)
    else $error("periodic work without permit");
  a_state_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_hit |=> ##1 functional_state == $past(bus_wdata[7:6], 2))
    else $error("functional state not written");
  a_ratio_bound: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_go && $past(ctrl.bulk_queue_permit) |-> $past(ctrl_cnt) < $past(ratio_limit))
    else $error("too many control endpoints before bulk");

  // bus, interrupt and state output side
  a_route_normal: assert property (@(posedge clk) disable iff (!nrst)
    hc_irq && !ctrl.interrupt_routing_select |=> normal_interrupt && !system_management_interrupt)
    else $error("interrupt not routed to normal line");
  a_ready_pulse: assert property (@(posedge clk) disable iff (!nrst)
    bus_sel |=> bus_ready)
    else $error("access not answered");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
    bus_ready && !$past(hit && !bus_write) |-> bus_rdata == 32'h0)
    else $error("read data without a read hit");
  a_state_copy: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> functional_state == $past(ctrl.functional_state))
    else $error("state output does not follow register");

  // scheduling side
  a_iso_needs_ed: assert property (@(posedge clk) disable iff (!nrst)
    iso_go |-> $past(iso_ed_found))
    else $error("iso served without a descriptor");
  a_list_oper: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_go || bulk_go |-> $past(oper))
    else $error("list served outside operational state");
  a_periodic_oper: assert property (@(posedge clk) disable iff (!nrst)
    periodic_frame_go |-> $past(oper))
    else $error("periodic work outside operational state");
  a_turn_bulk: assert property (@(posedge clk) disable iff (!nrst)
    bulk_go |-> list_turn == uhoc_pkg::LS_BULK)
    else $error("bulk turn not recorded");
  a_turn_ctrl: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_go |-> list_turn == uhoc_pkg::LS_CTRL)
    else $error("control turn not recorded");

endmodule

// >>> verif/uhoc_usb_dev.sv
// downstream device model: drives resume signaling only
// assumes the root hub syncs this level to the host clock
module uhoc_usb_dev (
  output logic resume_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  initial resume_detect = 1'b0;
  task automatic resume_signal(input int len);
    resume_detect = 1'b1;
    #(len);
    resume_detect = 1'b0;
  endtask
endmodule

// >>> verif/usb_host_operating_control_tb.sv
// testbench for the host operating-control register block
// assumes one clock and the registered slave port timing
module usb_host_operating_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A = 32'hfff05004;
  logic clk = 0, nrst = 0, sel = 0, wr = 0, irq = 0, fs = 0, iso = 0, slot = 0;
  logic [31:0] addr = 0, wd = 0, rd, d, rdv;
  logic rdy, nint, sysmgmt_irq, pgo, igo, cgo, bgo, res;
  logic [1:0] st;
  int errors = 0, total_checks = 0;
  always #50 clk = ~clk;
  uhoc_usb_dev i_uhoc_usb_dev (.resume_detect(res));
  uhoc_ctrl i_uhoc_ctrl (.clk(clk), .nrst(nrst), .bus_sel(sel), .bus_write(wr),
    .bus_addr(addr), .bus_wdata(wd), .bus_rdata(rd), .bus_ready(rdy),
    .resume_detect(res), .hc_irq(irq), .frame_start(fs), .iso_ed_found(iso),
    .nonperiodic_slot(slot), .normal_interrupt(nint),
    .system_management_interrupt(sysmgmt_irq), .functional_state(st),
    .periodic_frame_go(pgo), .iso_go(igo), .ctrl_go(cgo), .bulk_go(bgo));
  // ************************************************
  // tasks
  // ************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // sel stands one cycle; ready and data stand the next cycle only
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] v);
    @(negedge clk);
    sel = 1;
    wr = w;
    addr = a;
    wd = v;
    @(negedge clk) sel = 0;
    chk("ready", 1, rdy);
    rdv = rd;
  endtask
  task automatic pulse(input logic p, input logic f, input logic i);
    @(negedge clk);
    slot = p;
    fs = f;
    iso = i;
    @(negedge clk);
    slot = 0;
    fs = 0;
    iso = 0;
  endtask
  function automatic logic is_bulk(input int n, input int r);
    return (n % (r + 2)) == r + 1;
  endfunction
  // ************************************************
  // stimulus
  // ************************************************
  initial begin
    #1_000_000;
    errors++;
    results();
  end
  initial begin
    void'($urandom(92738));
    repeat (3) @(negedge clk);
    nrst = 1;
    acc(0, A, 0);
    chk("reset image", 0, rdv);
    for (int i = 0; i < 16; i++) begin
      d = $urandom();
      acc(1, A, d);
      acc(0, A, 0);
      chk("image", d & 32'h000005ff, rdv);
      chk("state", d[7:6], st);
      acc(1, 32'hfff05008, ~d);
      acc(0, 32'hfff05000, 0);
      chk("unmapped", 0, rdv);
      acc(0, A, 0);
      chk("kept", d & 32'h000005ff, rdv);
    end
    for (int r = 0; r < 2; r++) begin
      acc(1, A, r << 8);
      irq = 1;
      repeat (2) @(negedge clk);
      chk("normal", r == 0, nint);
      chk("sysmgmt", r == 1, sysmgmt_irq);
      irq = 0;
    end
    for (int k = 0; k < 2; k++) begin
      acc(1, A, k ? 32'h80 : 32'hc0);
      i_uhoc_usb_dev.resume_signal(500);
      repeat (2) @(negedge clk);
      acc(0, A, 0);
      chk("resume", k ? 2'h2 : 2'h1, rdv[7:6]);
    end
    for (int r = 0; r < 4; r++) begin
      nrst = 0;
      repeat (3) @(negedge clk);
      nrst = 1;
      acc(1, A, 32'hb0 | r);
      for (int n = 0; n < 8; n++) begin
        pulse(1, 0, 0);
        chk("ctrl_go", !is_bulk(n, r), cgo);
        chk("bulk_go", is_bulk(n, r), bgo);
      end
    end
    for (int k = 0; k < 3; k++) begin
      acc(1, A, k == 0 ? 32'ha0 : k == 1 ? 32'h90 : 32'h30);
      pulse(1, 0, 0);
      chk("ctrl gate", k == 1, cgo);
      chk("bulk gate", k == 0, bgo);
    end
    for (int k = 0; k < 3; k++) begin
      acc(1, A, k == 0 ? 32'h8c : k == 1 ? 32'h84 : 32'h80);
      pulse(0, 1, 0);
      chk("periodic", k < 2, pgo);
      pulse(0, 0, 1);
      chk("iso", k == 0, igo);
    end
    results();
  end
endmodule
